// *** rtl/flash_front_pkg.sv ***
// constants and types shared by the serial flash select/framing front end
//
// Overview of operation
// R1 - select high: ignore inputs, outputs high impedance
// R2 - deselected and idle means standby power
// R3 - select falling enters active power state
// R4 - after reset, first command needs select fall
// R5 - each operation starts on select falling edge
// R6 - each operation ends on select rising edge
// R7 - no standby until self-timed erase finishes
// R8 - sample serial input on rising clock
// R9 - shift output data on falling clock
// R10 - readable 128-bit unique serial number plus ids
// R11 - 256-byte page erase, constant erase time
// R12 - pause pin acts with select low, clock low
// R13 - quad enable turns pause/protect into data
// R14 - select rising mid-command abandons that command
package flash_front_pkg;

    // timing: one fixed erase time for page and chip alike
    localparam int unsigned CLOCK_PERIOD_NS = 5;
    localparam int unsigned ERASE_TIME_NS = 100000;
    localparam int unsigned ERASE_CYCLES_DEFAULT = ERASE_TIME_NS / CLOCK_PERIOD_NS;

    // frame geometry
    localparam logic [7:0] CMD_LAST_BIT = 8'h07;
    localparam logic [7:0] ADDR_LAST_BIT = 8'h17;
    localparam int unsigned PAGE_ADDR_LSB = 8;
    localparam int unsigned OUT_MSB = 127;

    // command codes
    localparam logic [7:0] CMD_READ_UNIQUE = 8'h01;
    localparam logic [7:0] CMD_READ_UNIQUE_QUAD = 8'h02;
    localparam logic [7:0] CMD_READ_IDENT = 8'h03;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h04;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h05;
    localparam logic [7:0] CMD_READ_BUSY = 8'h06;

    // pin positions inside the four data lines
    localparam int unsigned LINE_SERIAL_IN = 0;
    localparam int unsigned LINE_SERIAL_OUT = 1;
    localparam int unsigned LINE_PAUSE = 3;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_QUAD = 4'hf;

    // frame sequencer, gray along wait-cmd-addr-skip and wait-cmd-out
    typedef enum logic [2:0] {
        st_wait = 3'h0,
        st_cmd = 3'h1,
        st_addr = 3'h3,
        st_out = 3'h5,
        st_skip = 3'h7
    } frame_state_t;

    // pins after synchronisation
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic quad_io_enable_bit;
        logic [3:0] sio;
    } pins_t;

    // whole state of the front end
    typedef struct packed {
        frame_state_t st;
        logic sck_prev;
        logic cs_prev;
        logic paused;
        logic quad;
        logic [7:0] cnt;
        logic [23:0] in_sr;
        logic [127:0] out_sr;
        logic pend_page;
        logic pend_all;
        logic busy;
        logic [31:0] timer;
        logic erase_req;
        logic erase_all;
        logic [15:0] erase_page;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic standby;
    } front_state_t;

    // cs_prev resets low so a select held low at release is no fall
    localparam front_state_t FRONT_RESET = '{st: st_wait, standby: 1'b1, default: '0};

endpackage

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned WIDTH = 7
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic [WIDTH-1:0] ASYNC_I,
    output logic [WIDTH-1:0] SYNC_O
);

    genvar i;
    // one flop pair per bit; first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta;
            always_ff @(posedge CLOCK_I)
            begin
                if (RESET_I)
                begin
                    meta <= 1'b0;
                    SYNC_O[i] <= 1'b0;
                end
                else
                begin
                    meta <= ASYNC_I[i];
                    SYNC_O[i] <= meta;
                end
            end
        end
    endgenerate

endmodule

// *** rtl/serial_flash_select_framing.sv ***
// serial flash front end: select framing, power states, id read, erase timer
`timescale 1ns/100ps
module serial_flash_select_framing #(
    parameter int unsigned ERASE_CYCLES = flash_front_pkg::ERASE_CYCLES_DEFAULT,
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef0f1e2d3c4b5a6978, // arbitrary value
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_ID = 8'h3c // arbitrary value
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic QUAD_IO_ENABLE_BIT_I,
    input wire logic [3:0] SIO_I,
    output logic [3:0] SIO_O,
    output logic [3:0] SIO_OE_O,
    output logic STANDBY_O,
    output logic BUSY_O,
    output logic ERASE_REQ_O,
    output logic ERASE_ALL_O,
    output logic [15:0] ERASE_PAGE_O
);

    flash_front_pkg::pins_t raw; // pins before synchronising
    flash_front_pkg::pins_t pin; // pins after two flops
    flash_front_pkg::front_state_t s; // registered state
    flash_front_pkg::front_state_t n; // next state
    logic sck_r; // serial clock rising
    logic sck_f; // serial clock falling
    logic cs_fall; // select asserted
    logic cs_rise; // select released
    logic qe; // quad mode enabled
    logic [7:0] cmd; // command byte as it completes

    assign raw = '{sck: SCK_I, cs_n: CS_N_I, quad_io_enable_bit: QUAD_IO_ENABLE_BIT_I, sio: SIO_I};

    // every pin crosses from the host side through two flops
    pin_sync #(
        .WIDTH($bits(flash_front_pkg::pins_t))
    ) u_sync (
        .CLOCK_I(CLOCK_I),
        .RESET_I(RESET_I),
        .ASYNC_I(raw),
        .SYNC_O(pin)
    );

    // edge finding on the synchronised copies
    assign sck_r = pin.sck & ~s.sck_prev; // R8
    assign sck_f = ~pin.sck & s.sck_prev; // R9
    assign cs_fall = ~pin.cs_n & s.cs_prev;
    assign cs_rise = pin.cs_n & ~s.cs_prev;
    assign qe = pin.quad_io_enable_bit;
    assign cmd = {s.in_sr[6:0], pin.sio[flash_front_pkg::LINE_SERIAL_IN]};

    // next-state logic for the whole front end
    always_comb
    begin
        n = s;
        n.erase_req = 1'b0;
        n.sck_prev = pin.sck;
        n.cs_prev = pin.cs_n;
        // erase timer: the same count whatever was erased
        if (s.busy)
        begin
            if (s.timer == 32'h1) // R11
            begin
                n.busy = 1'b0;
            end
            n.timer = s.timer - 32'h1;
        end
        if (pin.cs_n)
        begin
            // deselected: drop outputs, forget any half command
            n.st = flash_front_pkg::st_wait; // R1 R14
            n.io_oe = 4'h0; // R1
            n.paused = 1'b0;
            n.quad = 1'b0;
            // a complete erase frame is acted on only when select rises
            if (cs_rise && s.st == flash_front_pkg::st_skip && (s.pend_page || s.pend_all) && !s.busy) // R6
            begin
                n.busy = 1'b1; // R7
                n.timer = ERASE_CYCLES;
                n.erase_req = 1'b1;
                n.erase_all = s.pend_all;
                n.erase_page = s.in_sr[23:flash_front_pkg::PAGE_ADDR_LSB]; // R11
            end
            n.pend_page = 1'b0;
            n.pend_all = 1'b0;
        end
        else if (cs_fall)
        begin
            // only a fall seen after reset opens a frame
            n.st = flash_front_pkg::st_cmd; // R4 R5
            n.cnt = 8'h0;
            n.pend_page = 1'b0;
            n.pend_all = 1'b0;
            n.quad = 1'b0;
        end
        else if (s.st != flash_front_pkg::st_wait)
        begin
            // pause pin only counts outside quad mode and with clock low
            if (qe)
            begin
                n.paused = 1'b0; // R13
            end
            else if (!pin.sck)
            begin
                n.paused = ~pin.sio[flash_front_pkg::LINE_PAUSE]; // R12
            end
            if (!s.paused && sck_r)
            begin
                // input bits on the rising clock edge
                unique case (s.st)
                    flash_front_pkg::st_cmd:
                    begin
                        n.in_sr = {s.in_sr[22:0], pin.sio[flash_front_pkg::LINE_SERIAL_IN]}; // R8
                        n.cnt = s.cnt + 8'h1;
                        if (s.cnt == flash_front_pkg::CMD_LAST_BIT)
                        begin
                            n.cnt = 8'h0;
                            n.st = flash_front_pkg::st_out;
                            // decode the finished command byte
                            unique case (cmd)
                                flash_front_pkg::CMD_READ_UNIQUE:
                                    n.out_sr = UNIQUE_ID; // R10
                                flash_front_pkg::CMD_READ_UNIQUE_QUAD:
                                begin
                                    n.out_sr = UNIQUE_ID; // R10
                                    n.quad = qe; // R13
                                end
                                flash_front_pkg::CMD_READ_IDENT:
                                    n.out_sr = {MAKER_ID, PART_ID, 112'h0}; // R10
                                flash_front_pkg::CMD_READ_BUSY:
                                    n.out_sr = {128{s.busy}};
                                flash_front_pkg::CMD_PAGE_ERASE:
                                    n.st = flash_front_pkg::st_addr;
                                flash_front_pkg::CMD_CHIP_ERASE:
                                begin
                                    n.st = flash_front_pkg::st_skip;
                                    n.pend_all = 1'b1;
                                end
                                default:
                                    n.st = flash_front_pkg::st_skip; // unknown code ignored
                            endcase
                        end
                    end
                    flash_front_pkg::st_addr:
                    begin
                        n.in_sr = {s.in_sr[22:0], pin.sio[flash_front_pkg::LINE_SERIAL_IN]}; // R8
                        n.cnt = s.cnt + 8'h1;
                        if (s.cnt == flash_front_pkg::ADDR_LAST_BIT)
                        begin
                            n.st = flash_front_pkg::st_skip;
                            n.pend_page = 1'b1;
                        end
                    end
                    flash_front_pkg::st_skip:
                    begin
                        // extra clocks spoil an erase frame
                        n.pend_page = 1'b0;
                        n.pend_all = 1'b0;
                    end
                    flash_front_pkg::st_out:
                        n.cnt = s.cnt;
                    default:
                        n.cnt = s.cnt;
                endcase
            end
            if (!s.paused && sck_f && s.st == flash_front_pkg::st_out)
            begin
                // output bits move on the falling clock edge
                if (s.quad)
                begin
                    n.io_out = s.out_sr[flash_front_pkg::OUT_MSB -: 4]; // R9 R13
                    n.io_oe = flash_front_pkg::OE_QUAD;
                    n.out_sr = {s.out_sr[123:0], 4'h0};
                end
                else
                begin
                    n.io_out = {2'h0, s.out_sr[flash_front_pkg::OUT_MSB], 1'b0}; // R9
                    n.io_oe = flash_front_pkg::OE_SINGLE;
                    n.out_sr = {s.out_sr[126:0], 1'b0};
                end
            end
        end
        // standby only while deselected with nothing self-timed running
        n.standby = n.cs_prev & ~n.busy; // R2 R3 R7
    end

    // state register, synchronous reset
    always_ff @(posedge CLOCK_I)
    begin
        if (RESET_I)
        begin
            s <= flash_front_pkg::FRONT_RESET;
        end
        else
        begin
            s <= n;
        end
    end

    // outputs straight from the state flops
    assign SIO_O = s.io_out;
    assign SIO_OE_O = s.io_oe;
    assign STANDBY_O = s.standby;
    assign BUSY_O = s.busy;
    assign ERASE_REQ_O = s.erase_req;
    assign ERASE_ALL_O = s.erase_all;
    assign ERASE_PAGE_O = s.erase_page;

    deselect_hiz_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R1
        pin.cs_n |=> SIO_OE_O == 4'h0) else $error("outputs driven while deselected");
    standby_follows_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R2
        (pin.cs_n && !s.busy && !cs_rise) |=> STANDBY_O) else $error("idle deselect not standby");
    active_on_select_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R3
        cs_fall |=> !STANDBY_O ##1 !STANDBY_O) else $error("select did not leave standby");
    powerup_gate_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R4
        (s.st == flash_front_pkg::st_wait && !pin.cs_n && !s.cs_prev) |=> s.st == flash_front_pkg::st_wait)
        else $error("frame opened without select fall");
    frame_start_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R5
        cs_fall |=> (s.st == flash_front_pkg::st_cmd && s.cnt == 8'h0)) else $error("fall did not open frame");
    frame_end_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R6
        $rose(pin.cs_n) |=> s.st == flash_front_pkg::st_wait) else $error("rise did not close frame");
    busy_no_standby_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R7
        BUSY_O |-> !STANDBY_O) else $error("standby during erase");
    rise_sample_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R8
        (s.st == flash_front_pkg::st_cmd && sck_r && !s.paused && !pin.cs_n && !cs_fall)
        |=> s.in_sr[0] == $past(pin.sio[0])) else $error("input bit not sampled");
    fall_shift_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R9
        (s.st == flash_front_pkg::st_out && sck_f && !s.paused && !s.quad && !pin.cs_n)
        |=> SIO_O[1] == $past(s.out_sr[127], 1) && SIO_OE_O == 4'h2) else $error("output bit not shifted");
    erase_busy_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R11
        $rose(ERASE_REQ_O) |-> BUSY_O ##1 (BUSY_O && !ERASE_REQ_O)) else $error("erase did not start timer");
    pause_hold_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R12
        (s.paused && !pin.cs_n && !cs_fall) |=> $stable(s.cnt) && $stable(s.in_sr))
        else $error("bits taken while paused");
    quad_gate_a: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // R13
        SIO_OE_O[3] |-> (s.quad && !s.paused)) else $error("quad drive without quad mode");

endmodule

// *** bench/flash_host_model.sv ***
// host serial controller model: select, clock and data lines
`timescale 1ns/100ps
module flash_host_model (
    input wire logic clk_i,
    input wire logic [3:0] pins_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] drv_o,
    output logic [3:0] drv_oe_o
);
    logic [511:0] rx; // lines seen at each rise, newest nibble lowest

    // clock stands low between frames, data line released
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        drv_o = 4'h9;
        drv_oe_o = 4'h0;
        rx = '0;
    end

    // one clock: data set while low, high 12 and low 13 cycles, 125 ns
    task automatic pulse(input logic b);
        drv_o[0] <= b;
        @(negedge clk_i);
        sck_o <= 1'b1;
        rx = {rx[507:0], pins_i};
        repeat (12) @(negedge clk_i);
        sck_o <= 1'b0;
        repeat (12) @(negedge clk_i);
    endtask

    // n bits msb first; rel lets go of line 0 for quad data
    task automatic shift(input int n, input logic [127:0] tx, input logic rel);
        drv_oe_o[0] <= !rel;
        for (int i = n - 1; i >= 0; i--) pulse(tx[i]);
    endtask

    // every frame opens on a select fall
    task automatic select();
        cs_n_o <= 1'b0;
        repeat (12) @(negedge clk_i);
    endtask

    // every frame closes on a select rise
    task automatic deselect();
        repeat (2) @(negedge clk_i);
        cs_n_o <= 1'b1;
        drv_oe_o[0] <= 1'b0;
        repeat (12) @(negedge clk_i);
    endtask

    // pause line moved only while the clock is low
    task automatic pause(input logic on);
        drv_oe_o[3] <= on;
        drv_o[3] <= !on;
        repeat (12) @(negedge clk_i);
    endtask
endmodule

// *** bench/serial_flash_select_framing_test.sv ***
// self-checking bench for the serial flash select and framing front end
`timescale 1ns/100ps
module serial_flash_select_framing_test;
    localparam int unsigned ERASE_N = 400; // short erase, still longer than a chip erase frame
    localparam logic [127:0] UID = 128'hfedcba98765432100123456789abcdef; // arbitrary value
    localparam logic [7:0] MAKER = 8'h6b; // arbitrary value
    localparam logic [7:0] PART = 8'h4e; // arbitrary value
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic quad_en = 1'b0;
    logic sck, cs_n, standby, busy, erase_req, erase_all;
    logic [3:0] drv, drv_oe, dev_o, dev_oe;
    logic [15:0] erase_page;
    wire logic [3:0] pins;
    int n_fail = 0;
    int compares = 0;
    int n_req = 0; // erase starts seen
    int busy_len = 0; // cycles with busy high

    always #2.5 clock = ~clock;

    // wire level; released lines read inverted, or pulled up
    assign pins[0] = dev_oe[0] ? dev_o[0] : (drv_oe[0] ? drv[0] : ~drv[0]);
    assign pins[1] = dev_oe[1] ? dev_o[1] : ~dev_o[1];
    assign pins[2] = dev_oe[2] ? dev_o[2] : 1'b1;
    assign pins[3] = dev_oe[3] ? dev_o[3] : (drv_oe[3] ? drv[3] : 1'b1);

    serial_flash_select_framing #(
        .ERASE_CYCLES(ERASE_N), .UNIQUE_ID(UID), .MAKER_ID(MAKER), .PART_ID(PART)
    ) dut (
        .CLOCK_I(clock), .RESET_I(reset), .SCK_I(sck), .CS_N_I(cs_n),
        .QUAD_IO_ENABLE_BIT_I(quad_en), .SIO_I(pins), .SIO_O(dev_o), .SIO_OE_O(dev_oe),
        .STANDBY_O(standby), .BUSY_O(busy), .ERASE_REQ_O(erase_req),
        .ERASE_ALL_O(erase_all), .ERASE_PAGE_O(erase_page)
    );

    flash_host_model host (
        .clk_i(clock), .pins_i(pins), .sck_o(sck), .cs_n_o(cs_n), .drv_o(drv), .drv_oe_o(drv_oe)
    );

    // count erase pulses and busy cycles; sampled mid-cycle where outputs are settled
    always @(negedge clock)
    begin
        if (erase_req === 1'b1)
            n_req++;
        if (busy === 1'b1)
            busy_len++;
    end

    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // bounded wait for the erase timer
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clock);
        repeat (3) @(negedge clock);
    endtask

    // eight output bits of line 1, starting at capture number at
    function automatic logic [7:0] lane1(input int at);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) b[i] = host.rx[4 * (at + i) + 1];
        return b;
    endfunction

    // select low across reset: the frame must be refused
    task automatic held_select();
        check(128'(dev_oe), 128'h0, "enables after reset");
        check(128'(standby), 128'h1, "standby after reset");
        host.shift(8, 128'(flash_front_pkg::CMD_CHIP_ERASE), 1'b0);
        host.deselect();
        repeat (20) @(negedge clock);
        check(128'(n_req + busy_len), 128'h0, "erase before first fall");
    endtask

    // single-lane unique id read, msb first
    task automatic read_unique();
        logic [127:0] id;
        host.select();
        host.shift(8, 128'(flash_front_pkg::CMD_READ_UNIQUE), 1'b0);
        check(128'(standby), 128'h0, "active in frame");
        host.shift(128, 128'h0, 1'b0);
        check(128'(dev_oe), 128'h2, "single lane enable");
        for (int i = 0; i < 128; i++) id[i] = host.rx[4 * i + 1];
        check(id, UID, "unique id");
        host.deselect();
        check(128'(dev_oe), 128'h0, "released after frame");
        check(128'(standby), 128'h1, "standby after frame");
    endtask

    // ident read with three clocks sent during a pause
    task automatic ident_paused();
        host.select();
        host.shift(8, 128'(flash_front_pkg::CMD_READ_IDENT), 1'b0);
        host.shift(8, 128'h0, 1'b0);
        host.pause(1'b1);
        host.shift(3, 128'h5, 1'b0);
        host.pause(1'b0);
        host.shift(8, 128'h0, 1'b0);
        host.deselect();
        check(128'({lane1(11), lane1(0)}), 128'({MAKER, PART}), "ident across pause");
    endtask

    // select rise after 12 bits drops the erase; next frame still works
    task automatic abort_frame();
        n_req = 0;
        host.select();
        host.shift(12, 128'({flash_front_pkg::CMD_PAGE_ERASE, 4'ha}), 1'b0);
        host.deselect();
        repeat (20) @(negedge clock);
        check(128'(n_req), 128'h0, "aborted erase");
        host.select();
        host.shift(24, 128'({flash_front_pkg::CMD_READ_IDENT, 16'h0}), 1'b0);
        host.deselect();
        check(128'({lane1(8), lane1(0)}), 128'({MAKER, PART}), "ident after abort");
    endtask

    // page erase: page index, busy span, no standby while busy
    task automatic page_erase();
        n_req = 0;
        busy_len = 0;
        host.select();
        host.shift(32, 128'({flash_front_pkg::CMD_PAGE_ERASE, 16'ha5c3, 8'h7e}), 1'b0);
        host.deselect();
        check(128'({busy, standby}), 128'h2, "busy, not standby");
        host.select();
        host.shift(16, 128'({flash_front_pkg::CMD_READ_BUSY, 8'h0}), 1'b0);
        host.deselect();
        check(128'(lane1(0)), 128'hff, "busy read while erasing");
        wait_idle();
        check(128'(n_req), 128'h1, "one page erase");
        check(128'(busy_len), 128'(ERASE_N), "page erase time");
        check(128'({erase_all, erase_page}), 128'h0a5c3, "page index");
        check(128'(standby), 128'h1, "standby after erase");
    endtask

    // chip erase takes the same time; a second erase while busy is dropped
    task automatic chip_erase_busy();
        n_req = 0;
        busy_len = 0;
        repeat (2)
        begin
            host.select();
            host.shift(8, 128'(flash_front_pkg::CMD_CHIP_ERASE), 1'b0);
            host.deselect();
        end
        wait_idle();
        check(128'(n_req), 128'h1, "one chip erase");
        check(128'(busy_len), 128'(ERASE_N), "chip erase time");
        check(128'(erase_all), 128'h1, "whole chip");
        host.select();
        host.shift(16, 128'({flash_front_pkg::CMD_READ_BUSY, 8'h0}), 1'b0);
        host.deselect();
        check(128'(lane1(0)), 128'h0, "busy read when idle");
    endtask

    // quad read; pause line low must not pause with quad enabled
    task automatic quad_read();
        quad_en = 1'b1;
        repeat (6) @(negedge clock);
        host.select();
        host.pause(1'b1);
        host.shift(8, 128'(flash_front_pkg::CMD_READ_UNIQUE_QUAD), 1'b0);
        host.pause(1'b0);
        host.shift(32, 128'h0, 1'b1);
        check(128'(dev_oe), 128'hf, "quad enables");
        check(host.rx[127:0], UID, "quad unique id");
        host.deselect();
        quad_en = 1'b0;
    endtask

    // main sequence; reset held three cycles, select already low across release
    initial
    begin
        @(negedge clock);
        host.cs_n_o = 1'b0;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        held_select();
        read_unique();
        ident_paused();
        abort_frame();
        page_erase();
        chip_erase_busy();
        quad_read();
        final_report();
    end

    // watchdog, well beyond the roughly 44 us the tests need
    initial
    begin
        #200000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule
